//--- common/pps_params.svh
// Offsets, field positions, reset values and timing for the scheduler
`ifndef PPS_PARAMS_SVH
`define PPS_PARAMS_SVH

// ============================================================
// Register byte offsets
`define PPS_OFF_CMD      8'h00
`define PPS_OFF_OPERAND  8'h04
`define PPS_OFF_OPND_IP  8'h08
`define PPS_OFF_STATUS   8'h0c
`define PPS_OFF_CUR_WD   8'h10
`define PPS_OFF_CUR_IP   8'h14
`define PPS_OFF_STACK    8'h18
`define PPS_OFF_RES_WD   8'h1c
`define PPS_OFF_RES_IP   8'h20
`define PPS_OFF_BP_WD    8'h24
`define PPS_OFF_BP_IP    8'h28
`define PPS_OFF_SLOT_SEL 8'h2c
`define PPS_OFF_SLOT_ADR 8'h30

// ============================================================
// Descriptor fields
`define PPS_PRIO_BIT     0
`define PPS_TYPE_BIT     1
`define PPS_PRIO_HIGH    1'b0
`define PPS_PRIO_LOW     1'b1
`define PPS_TYPE_GLOBAL  1'b0
`define PPS_TYPE_LOCAL   1'b1

// ============================================================
// Values and resets
`define PPS_TRUE         32'h0000_0001
`define PPS_FALSE        32'h0000_0000
`define PPS_ZERO32       32'h0000_0000
`define PPS_HALT_MSG     8'he1
`define PPS_TICKS_DUE    2'h2
`define PPS_SLOT_RESET   3'h1

// ============================================================
// Timing: timeslice period in microseconds, clock in MHz
`define PPS_TS_PERIOD_US 1000
`define PPS_CLK_MHZ      40

`endif

//--- common/pps_pkg.sv
// Types shared by the process scheduler
package pps_pkg;

    // ========================================================
    // Operation codes written to the command register
    typedef enum logic [4:0] {
        PPS_OP_NOP,
        PPS_OP_START,
        PPS_OP_WAIT,
        PPS_OP_END,
        PPS_OP_TSPOINT,
        PPS_OP_JUMP_ZERO,
        PPS_OP_TESTERR,
        PPS_OP_STOPERR,
        PPS_OP_FPTESTERR,
        PPS_OP_FPCHKERR,
        PPS_OP_SETERR,
        PPS_OP_SETFPERR,
        PPS_OP_CLRFPERR,
        PPS_OP_SETHALT,
        PPS_OP_CLRHALT,
        PPS_OP_ENABLE_BP,
        PPS_OP_SHADOW_STORE,
        PPS_OP_SHADOW_LOAD,
        PPS_OP_SWAP_QUEUE
    } pps_op_e;

    // ========================================================
    // One process: descriptor word and instruction pointer
    typedef struct packed {
        logic [31:0] wdesc;
        logic [31:0] ip;
    } pps_proc_s;

    // ========================================================
    // Status register layout
    typedef struct packed {
        logic [7:0] rsvd;
        logic [3:0] lo_count;
        logic [3:0] hi_count;
        logic [4:0] rsvd2;
        logic       slot2_count;
        logic       refused;
        logic       halted;
        logic       bp_enabled;
        logic       halt_flag;
        logic       fpu_err;
        logic       cpu_err;
        logic       shadow_valid;
        logic       cur_type;
        logic       cur_prio;
        logic       running;
    } pps_status_s;

endpackage : pps_pkg

//--- src/pps_scheduler.sv
// Two-level process scheduler with error flags and breakpoint jump
//
// Function
// - Low priority runs only without active high
// - Front high process runs until wait/end
// - Else pick low process, timesliced evenly
// - Round robin bounds low start latency
// - Ready high preempts low into shadow
// - Resume shadowed low when high drains
// - High process stores and loads shadow
// - Swap alternative queue with either queue
// - Descriptor bit 0 is priority, 1 low
// - Descriptor bit 1 is type, 1 local
// - Both types coexist, behaviour follows type
// - Global workspace slots at offsets minus one-five
// - Slot minus two shared: link or count
// - Separate integer and floating error flags
// - Test error loads flag result, clears flag
// - Stop on error deschedules when flagged
// - Float test error loads flag result
// - Float check ORs into integer flag
// - Halt flag with error halts, emits message
// - Jump zero no-op until breakpoint enabled; here it acts as a timeslice point instead
// - Breakpoint swaps ip and wptr with pair
// - Breakpoint: no timeslice, stack unchanged
// - Low process descheduled after two periods
//
// Our own choices: the APB register port and the address map.
`include "pps_params.svh"

module pps_scheduler #(
    parameter int QDEPTH           = 8,
    parameter int TS_PERIOD_CYCLES = `PPS_TS_PERIOD_US * `PPS_CLK_MHZ
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Fault events from the execution units
    input  wire logic        cpu_fault_evt,
    input  wire logic        fpu_fault_evt,
    // Halt and control link zero message
    output logic             halted,
    output logic             control_link_zero_valid,
    output logic [7:0]       control_link_zero_data
);
    import pps_pkg::*;

    localparam int QW = $clog2(QDEPTH);
    localparam int TW = $clog2(TS_PERIOD_CYCLES);
    localparam logic [QW:0]   QFULL   = QW'(0) + (QW+1)'(QDEPTH);
    localparam logic [TW-1:0] TS_LAST = TW'(TS_PERIOD_CYCLES - 1);

    // ========================================================
    // State
    logic [31:0] operand;
    logic [31:0] opnd_ip;
    logic [2:0]  slot_sel;
    pps_op_e     cmd_op;
    logic        cmd_pend;
    logic        do_op;
    pps_proc_s   cur;
    pps_proc_s   shadow;
    pps_proc_s   result;
    pps_proc_s   bp_pair;
    logic        running;
    logic        shadow_valid;
    logic        bp_enabled;
    logic        refused;
    logic [1:0]  run_ticks;
    logic [TW-1:0] tick_cnt;
    logic        tick;
    logic        cpu_error_flag;
    logic        fpu_error_flag;
    logic        halt_on_fault_flag;
    logic [31:0] stack_top;
    logic [1:0]  qmap [2];
    logic [1:0]  qalt;
    pps_proc_s   qmem [3][QDEPTH];
    logic [QW-1:0] qhead [3];
    logic [QW:0]   qcnt  [3];
    logic [1:0]  hb;
    logic [1:0]  lb;
    logic        hi_ready;
    logic        lo_ready;
    logic        cur_low;
    logic        ts_due;
    logic        apb_wr;
    logic        next_cpu_err;
    logic        next_fpu_err;
    pps_status_s status;
    logic [31:0] rd_word;
    logic        rd_hit;

    // ========================================================
    // Helpers
    // Ring index wrap; QDEPTH must be a power of two
    function automatic logic [QW-1:0] ring_add(input logic [QW-1:0] h,
                                               input logic [QW:0]   n);
        ring_add = QW'(h + n[QW-1:0]);
    endfunction : ring_add

    // Byte address of a global-process workspace slot below wptr
    function automatic logic [31:0] slot_addr(input logic [31:0] wd,
                                              input logic [2:0]  k);
        slot_addr = {wd[31:2], 2'b00} - {27'h0, k, 2'b00};
    endfunction : slot_addr

    // ========================================================
    // Queue selection and scheduling conditions
    assign hb       = qmap[0];
    assign lb       = qmap[1];
    assign hi_ready = qcnt[hb] != '0;
    assign lo_ready = qcnt[lb] != '0;
    assign cur_low  = cur.wdesc[`PPS_PRIO_BIT] == `PPS_PRIO_LOW;
    assign ts_due   = run_ticks == `PPS_TICKS_DUE;
    assign do_op    = cmd_pend && !halted;
    assign apb_wr   = psel && penable && pready && pwrite;

    // ========================================================
    // Timeslice period ticker, free running
    always_ff @(posedge clock) begin
        if (reset) begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end else begin
            tick     <= tick_cnt == TS_LAST;
            tick_cnt <= (tick_cnt == TS_LAST) ? '0 : TW'(tick_cnt + 1'b1);
        end
    end

    // ========================================================
    // Software-written registers and command capture
    always_ff @(posedge clock) begin
        if (reset) begin
            operand  <= `PPS_ZERO32;
            opnd_ip  <= `PPS_ZERO32;
            slot_sel <= `PPS_SLOT_RESET;
            cmd_op   <= PPS_OP_NOP;
            cmd_pend <= 1'b0;
        end else begin
            cmd_pend <= apb_wr && paddr == `PPS_OFF_CMD;
            if (apb_wr) begin
                unique case (paddr)
                    `PPS_OFF_CMD:      cmd_op   <= pps_op_e'(pwdata[4:0]);
                    `PPS_OFF_OPERAND:  operand  <= pwdata;
                    `PPS_OFF_OPND_IP:  opnd_ip  <= pwdata;
                    `PPS_OFF_SLOT_SEL: slot_sel <= pwdata[2:0];
                    default: ;
                endcase
            end
        end
    end

    // ========================================================
    // Scheduler: queues, current process, shadow, breakpoint pair
    // Commands and dispatch never share a cycle, so each queue sees
    // at most one push and one pop per edge.
    always_ff @(posedge clock) begin
        if (reset) begin
            running      <= 1'b0;
            cur          <= '0;
            shadow       <= '0;
            shadow_valid <= 1'b0;
            result       <= '0;
            bp_pair      <= '0;
            bp_enabled   <= 1'b0;
            refused      <= 1'b0;
            run_ticks    <= '0;
            qmap[0]      <= 2'h0;
            qmap[1]      <= 2'h1;
            qalt         <= 2'h2;
            for (int b = 0; b < 3; b++) begin
                qhead[b] <= '0;
                qcnt[b]  <= '0;
            end
        end else begin
            if (tick && !ts_due)
                run_ticks <= 2'(run_ticks + 1'b1);
            if (apb_wr && paddr == `PPS_OFF_BP_WD)
                bp_pair.wdesc <= pwdata;
            if (apb_wr && paddr == `PPS_OFF_BP_IP)
                bp_pair.ip <= pwdata;
            if (do_op) begin
                refused <= 1'b0;
                unique case (cmd_op)
                    PPS_OP_START: begin
                        // Priority bit picks the queue; new work joins tail
                        if (qcnt[qmap[operand[`PPS_PRIO_BIT]]] != QFULL) begin
                            qmem[qmap[operand[`PPS_PRIO_BIT]]]
                                [ring_add(qhead[qmap[operand[`PPS_PRIO_BIT]]],
                                          qcnt[qmap[operand[`PPS_PRIO_BIT]]])]
                                <= '{wdesc: operand, ip: opnd_ip};
                            qcnt[qmap[operand[`PPS_PRIO_BIT]]] <=
                                (QW+1)'(qcnt[qmap[operand[`PPS_PRIO_BIT]]] + 1'b1);
                        end else begin
                            refused <= 1'b1;
                        end
                    end
                    PPS_OP_WAIT, PPS_OP_END: begin
                        running <= 1'b0;
                        result  <= cur;
                    end
                    PPS_OP_STOPERR: begin
                        if (cpu_error_flag) begin
                            running <= 1'b0;
                            result  <= cur;
                        end
                    end
                    PPS_OP_TSPOINT, PPS_OP_JUMP_ZERO: begin
                        if (cmd_op == PPS_OP_JUMP_ZERO && bp_enabled &&
                            cur.wdesc[`PPS_TYPE_BIT] == `PPS_TYPE_GLOBAL) begin
                            // Breakpoint: swap, keep ticks and stack
                            cur.wdesc[31:2] <= bp_pair.wdesc[31:2];
                            cur.ip          <= bp_pair.ip;
                            bp_pair.wdesc   <= {cur.wdesc[31:2], 2'b00};
                            bp_pair.ip      <= cur.ip;
                        end else if (running && cur_low && ts_due &&
                                     lo_ready) begin
                            // Rotate: old process to tail, front runs
                            qmem[lb][ring_add(qhead[lb], qcnt[lb])] <= cur;
                            cur       <= qmem[lb][qhead[lb]];
                            qhead[lb] <= ring_add(qhead[lb], (QW+1)'(1));
                            run_ticks <= '0;
                        end
                    end
                    PPS_OP_ENABLE_BP: bp_enabled <= 1'b1;
                    PPS_OP_SHADOW_STORE: begin
                        if (running && !cur_low)
                            result <= shadow;
                        else
                            refused <= 1'b1;
                    end
                    PPS_OP_SHADOW_LOAD: begin
                        if (running && !cur_low) begin
                            shadow       <= '{wdesc: operand, ip: opnd_ip};
                            shadow_valid <= 1'b1;
                        end else begin
                            refused <= 1'b1;
                        end
                    end
                    PPS_OP_SWAP_QUEUE: begin
                        qmap[operand[`PPS_PRIO_BIT]] <= qalt;
                        qalt <= qmap[operand[`PPS_PRIO_BIT]];
                    end
                    default: ;
                endcase
            end else if (!halted) begin
                if (running && cur_low && hi_ready) begin
                    // Preempt low work into shadow
                    shadow       <= cur;
                    shadow_valid <= 1'b1;
                    cur          <= qmem[hb][qhead[hb]];
                    qhead[hb]    <= ring_add(qhead[hb], (QW+1)'(1));
                    qcnt[hb]     <= (QW+1)'(qcnt[hb] - 1'b1);
                end else if (!running && hi_ready) begin
                    running   <= 1'b1;
                    cur       <= qmem[hb][qhead[hb]];
                    qhead[hb] <= ring_add(qhead[hb], (QW+1)'(1));
                    qcnt[hb]  <= (QW+1)'(qcnt[hb] - 1'b1);
                end else if (!running && shadow_valid) begin
                    running      <= 1'b1;
                    cur          <= shadow;
                    shadow_valid <= 1'b0;
                end else if (!running && lo_ready) begin
                    running   <= 1'b1;
                    cur       <= qmem[lb][qhead[lb]];
                    qhead[lb] <= ring_add(qhead[lb], (QW+1)'(1));
                    qcnt[lb]  <= (QW+1)'(qcnt[lb] - 1'b1);
                    run_ticks <= '0;
                end
            end
        end
    end

    // ========================================================
    // Error flags: a fault in the clearing cycle still sets
    always_comb begin
        next_cpu_err = cpu_error_flag;
        next_fpu_err = fpu_error_flag;
        if (do_op && cmd_op == PPS_OP_TESTERR)
            next_cpu_err = 1'b0;
        if (do_op && cmd_op == PPS_OP_CLRFPERR)
            next_fpu_err = 1'b0;
        if (cpu_fault_evt || (do_op && cmd_op == PPS_OP_SETERR))
            next_cpu_err = 1'b1;
        if (do_op && cmd_op == PPS_OP_FPCHKERR && fpu_error_flag)
            next_cpu_err = 1'b1;
        if (fpu_fault_evt || (do_op && cmd_op == PPS_OP_SETFPERR))
            next_fpu_err = 1'b1;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            cpu_error_flag     <= 1'b0;
            fpu_error_flag     <= 1'b0;
            halt_on_fault_flag <= 1'b0;
        end else begin
            cpu_error_flag <= next_cpu_err;
            fpu_error_flag <= next_fpu_err;
            if (do_op && cmd_op == PPS_OP_SETHALT)
                halt_on_fault_flag <= 1'b1;
            if (do_op && cmd_op == PPS_OP_CLRHALT)
                halt_on_fault_flag <= 1'b0;
        end
    end

    // ========================================================
    // Stack top: loaded only by the two test operations
    always_ff @(posedge clock) begin
        if (reset) begin
            stack_top <= `PPS_ZERO32;
        end else if (do_op && cmd_op == PPS_OP_TESTERR) begin
            stack_top <= cpu_error_flag ? `PPS_FALSE : `PPS_TRUE;
        end else if (do_op && cmd_op == PPS_OP_FPTESTERR) begin
            stack_top <= fpu_error_flag ? `PPS_FALSE : `PPS_TRUE;
        end
    end

    // ========================================================
    // Halt; only reset leaves it, one message per halt
    always_ff @(posedge clock) begin
        if (reset) begin
            halted                  <= 1'b0;
            control_link_zero_valid <= 1'b0;
            control_link_zero_data  <= '0;
        end else begin
            control_link_zero_valid <= 1'b0;
            if (!halted && halt_on_fault_flag && cpu_error_flag) begin
                halted                  <= 1'b1;
                control_link_zero_valid <= 1'b1;
                control_link_zero_data  <= `PPS_HALT_MSG;
            end
        end
    end

    // ========================================================
    // Status word and read decode
    always_comb begin
        status              = '0;
        status.running      = running;
        status.cur_prio     = cur.wdesc[`PPS_PRIO_BIT];
        status.cur_type     = cur.wdesc[`PPS_TYPE_BIT];
        status.shadow_valid = shadow_valid;
        status.cpu_err      = cpu_error_flag;
        status.fpu_err      = fpu_error_flag;
        status.halt_flag    = halt_on_fault_flag;
        status.bp_enabled   = bp_enabled;
        status.halted       = halted;
        status.refused      = refused;
        status.slot2_count  = running;
        status.hi_count     = 4'(qcnt[hb]);
        status.lo_count     = 4'(qcnt[lb]);
    end

    always_comb begin
        rd_hit  = 1'b1;
        rd_word = `PPS_ZERO32;
        unique case (paddr)
            `PPS_OFF_CMD:      rd_word = {27'h0, cmd_op};
            `PPS_OFF_OPERAND:  rd_word = operand;
            `PPS_OFF_OPND_IP:  rd_word = opnd_ip;
            `PPS_OFF_STATUS:   rd_word = status;
            `PPS_OFF_CUR_WD:   rd_word = cur.wdesc;
            `PPS_OFF_CUR_IP:   rd_word = cur.ip;
            `PPS_OFF_STACK:    rd_word = stack_top;
            `PPS_OFF_RES_WD:   rd_word = result.wdesc;
            `PPS_OFF_RES_IP:   rd_word = result.ip;
            `PPS_OFF_BP_WD:    rd_word = bp_pair.wdesc;
            `PPS_OFF_BP_IP:    rd_word = bp_pair.ip;
            `PPS_OFF_SLOT_SEL: rd_word = {29'h0, slot_sel};
            `PPS_OFF_SLOT_ADR: rd_word = slot_addr(operand, slot_sel);
            default:           rd_hit  = 1'b0;
        endcase
    end

    // ========================================================
    // APB answer: one wait-free access phase, data taken at setup
    always_ff @(posedge clock) begin
        if (reset) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= `PPS_ZERO32;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !rd_hit;
            if (psel && !penable)
                prdata <= pwrite ? `PPS_ZERO32 : rd_word;
        end
    end

endmodule : pps_scheduler

//--- bench/pps_scheduler_assertions.sv
// Port-level checker for the process scheduler, bound to its top module
module pps_sched_chk (
    // Clock and reset
    input wire logic        clock,
    input wire logic        reset,
    // APB slave
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Halt and message
    input wire logic        halted,
    input wire logic        control_link_zero_valid,
    input wire logic [7:0]  control_link_zero_data
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    // ========================================================
    // Bus answers: no wait state, single-cycle ready
    apb_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    ready_once_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    // Refused reads must not leak stale data
    err_data_a: assert property (pready && pslverr && !pwrite |-> prdata == 0)
        else $error("refused read data not zero");

    // ========================================================
    // Halt is sticky and announced once with the fixed code
    halt_stay_a: assert property (halted |=> halted)
        else $error("halt released");
    halt_msg_a: assert property ($rose(halted) |-> control_link_zero_valid)
        else $error("halt without message");
    msg_code_a: assert property (control_link_zero_valid |->
        control_link_zero_data == 8'he1)
        else $error("wrong halt message");
    msg_once_a: assert property (control_link_zero_valid |->
        halted && !$past(halted) ##1 !control_link_zero_valid)
        else $error("message not a single pulse");
endmodule : pps_sched_chk

bind pps_scheduler pps_sched_chk chk_i (.clock, .reset, .psel, .penable,
    .pwrite, .prdata, .pready, .pslverr, .halted, .control_link_zero_valid,
    .control_link_zero_data);

//--- bench/tb_top.sv
// Self-checking bench for the process scheduler over APB
`include "pps_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pps_pkg::*;

    localparam logic [7:0] ST = `PPS_OFF_STATUS;
    localparam logic [7:0] WD = `PPS_OFF_CUR_WD;
    localparam logic [7:0] SK = `PPS_OFF_STACK;
    localparam logic [7:0] BW = `PPS_OFF_BP_WD;
    localparam logic [31:0] LQ = 32'h00f0_0000;
    logic        clock, reset, psel, penable, pwrite, pready, pslverr;
    logic        cpu_fault_evt, fpu_fault_evt, halted;
    logic        control_link_zero_valid;
    logic [7:0]  paddr, control_link_zero_data;
    logic [31:0] pwdata, prdata, ip_a, ip_b;
    logic [31:0] seed = 32'h1b45;
    logic [32:0] q_exp[$];
    logic [31:0] q_msk[$];
    string       q_nm[$];
    int          num_errors = 0;
    int          n_checks = 0;
    int          n_msg = 0;
    int          cyc = 0;

    // Short timeslice so the tick counts stay in a short run
    pps_scheduler #(.QDEPTH(8), .TS_PERIOD_CYCLES(40)) uut (.clock, .reset,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .cpu_fault_evt, .fpu_fault_evt, .halted,
        .control_link_zero_valid, .control_link_zero_data);

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic chk(string nm, logic [32:0] e, logic [32:0] s);
        n_checks++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    // Request held until ready is sampled high at a rising edge
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge keeps the next setup out of this time step
        @(posedge clock);
    endtask : apb

    task automatic rd(logic [7:0] a, logic [32:0] e, logic [31:0] m,
                      string nm);
        q_exp.push_back(e);
        q_msk.push_back(m);
        q_nm.push_back(nm);
        apb(1'b0, a, 32'h0);
    endtask : rd

    // Command needs two edges before its effect can be read
    task automatic op(pps_op_e o, logic [31:0] d);
        apb(1'b1, `PPS_OFF_OPERAND, d);
        apb(1'b1, `PPS_OFF_CMD, 32'(o));
        repeat (2) @(posedge clock);
    endtask : op

    task automatic evt(logic c, logic f);
        cpu_fault_evt <= c;
        fpu_fault_evt <= f;
        @(posedge clock);
        cpu_fault_evt <= 1'b0;
        fpu_fault_evt <= 1'b0;
        @(posedge clock);
    endtask : evt

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : summarize

    // Read results compared against the oldest note in the queue
    always @(posedge clock) begin
        if (psel && penable && pready === 1'b1 && !pwrite && q_nm.size())
            chk(q_nm.pop_front(), q_exp.pop_front(),
                {pslverr, prdata & q_msk.pop_front()});
    end

    // Halt message taken as it pulses; one pulse per halt
    always @(posedge clock) begin
        if (control_link_zero_valid === 1'b1) begin
            n_msg++;
            chk("msg", 33'(`PPS_HALT_MSG),
                33'(control_link_zero_data));
        end
    end

    // Run is a few hundred cycles; the ceiling catches a hang
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            summarize();
        end
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {cpu_fault_evt, fpu_fault_evt} = 2'b00;
        reset = 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        rd(ST, 33'h0, '1, "status");
        rd(`PPS_OFF_SLOT_SEL, 33'h1, 32'h7, "slot_sel");
        rd(8'h40, {1'b1, 32'h0}, '1, "unmapped");
        apb(1'b1, `PPS_OFF_OPERAND, 32'h1003);
        apb(1'b1, `PPS_OFF_SLOT_SEL, 32'h4);
        rd(`PPS_OFF_SLOT_ADR, 33'hff0, '1, "slot_adr");
        $display("test reset done");
        ip_a = rnd();
        ip_b = rnd();
        apb(1'b1, `PPS_OFF_OPND_IP, ip_a);
        op(PPS_OP_START, 32'h101);
        rd(WD, 33'h101, '1, "cur_wd");
        rd(ST, 33'h3, 32'h7, "status");
        apb(1'b1, `PPS_OFF_OPND_IP, ip_b);
        op(PPS_OP_START, 32'h202);
        rd(WD, 33'h202, '1, "cur_wd");
        rd(ST, 33'hd, 32'hf, "status");
        op(PPS_OP_END, 32'h0);
        rd(`PPS_OFF_RES_WD, 33'h202, '1, "res_wd");
        rd(`PPS_OFF_CUR_IP, {1'b0, ip_a}, '1, "cur_ip");
        rd(ST, 33'h3, 32'hf, "status");
        rd(ST, 33'h400, 32'h400, "slot2");
        $display("test priority done");
        evt(1'b1, 1'b0);
        rd(ST, 33'h10, 32'h30, "status");
        op(PPS_OP_TESTERR, 32'h0);
        rd(SK, 33'h0, '1, "stack");
        op(PPS_OP_TESTERR, 32'h0);
        rd(SK, 33'h1, '1, "stack");
        evt(1'b0, 1'b1);
        op(PPS_OP_FPTESTERR, 32'h0);
        rd(SK, 33'h0, '1, "stack");
        op(PPS_OP_FPCHKERR, 32'h0);
        rd(ST, 33'h30, 32'h30, "status");
        op(PPS_OP_STOPERR, 32'h0);
        rd(ST, 33'h0, 32'h1, "status");
        op(PPS_OP_TESTERR, 32'h0);
        $display("test errors done");
        apb(1'b1, `PPS_OFF_OPND_IP, ip_a);
        op(PPS_OP_START, 32'h301);
        apb(1'b1, `PPS_OFF_OPND_IP, ip_b);
        op(PPS_OP_START, 32'h501);
        op(PPS_OP_TSPOINT, 32'h0);
        rd(WD, 33'h301, '1, "cur_wd");
        repeat (100) @(posedge clock);
        op(PPS_OP_TSPOINT, 32'h0);
        rd(WD, 33'h501, '1, "cur_wd");
        rd(ST, {1'b0, 32'h0010_0000}, LQ, "lo_count");
        op(PPS_OP_SWAP_QUEUE, 32'h1);
        rd(ST, 33'h0, LQ, "lo_count");
        op(PPS_OP_SWAP_QUEUE, 32'h1);
        rd(ST, {1'b0, 32'h0010_0000}, LQ, "lo_count");
        op(PPS_OP_SHADOW_STORE, 32'h0);
        rd(ST, 33'h200, 32'h200, "refused");
        $display("test timeslice done");
        apb(1'b1, BW, 32'h400);
        apb(1'b1, `PPS_OFF_BP_IP, 32'h44);
        // Let the slice fall due so the plain jump must rotate
        repeat (100) @(posedge clock);
        op(PPS_OP_JUMP_ZERO, 32'h0);
        rd(BW, 33'h400, '1, "bp_wd");
        rd(WD, 33'h301, '1, "cur_wd");
        op(PPS_OP_ENABLE_BP, 32'h0);
        rd(ST, 33'h80, 32'h80, "bp_on");
        op(PPS_OP_TESTERR, 32'h0);
        op(PPS_OP_JUMP_ZERO, 32'h0);
        rd(WD, 33'h401, '1, "cur_wd");
        rd(`PPS_OFF_CUR_IP, 33'h44, '1, "cur_ip");
        rd(BW, 33'h300, '1, "bp_wd");
        rd(SK, 33'h1, '1, "stack");
        $display("test breakpoint done");
        op(PPS_OP_SETHALT, 32'h0);
        @(negedge clock);
        chk("halted", 33'h0, {32'h0, halted});
        @(posedge clock);
        evt(1'b1, 1'b0);
        repeat (2) @(posedge clock);
        @(negedge clock);
        chk("halted", 33'h1, {32'h0, halted});
        chk("msg_count", 33'h1, 33'(n_msg));
        $display("test halt done");
        summarize();
    end
endmodule : tb_top
